/* hdl/sapr_consts.vh */
// Constants for the parallel readout converter control block
`ifndef SAPR_CONSTS_VH
`define SAPR_CONSTS_VH
`define SAPR_CLK_PERIOD_NS 100
`define SAPR_CONV_TIME_NS  610
// One clock per result bit plus the latch clock, longer than 610 ns at this clock
`define SAPR_CONV_CYCLES   5'h11
`define SAPR_CNT_W         5
`define SAPR_PIN_N         4
`define SAPR_PIN_CS        0
`define SAPR_PIN_CV        1
`define SAPR_PIN_RD        2
`define SAPR_PIN_BY        3
`define SAPR_PIN_IDLE      4'h7
`define SAPR_RES_W         16
`define SAPR_BYTE_W        8
`define SAPR_RES_ZERO      16'h0000
`define SAPR_ONES_BYTE     8'hFF
`define SAPR_SAR_MSB       16'h8000
`endif

/* hdl/sapr_sar.v */
// Successive approximation register stepping one bit per clock
`timescale 1ns/1ps
`default_nettype none
`include "sapr_consts.vh"
module sapr_sar (
   input  wire        clk_in,
   input  wire        rst_in,
   input  wire        start_in,
   input  wire        step_in,
   input  wire        cmp_hi_in,
   output reg  [15:0] trial_out
);
   reg  [15:0] bit_q;
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         trial_out <= `SAPR_RES_ZERO;
         bit_q     <= `SAPR_RES_ZERO;
      end else if (start_in) begin
         trial_out <= `SAPR_SAR_MSB;
         bit_q     <= `SAPR_SAR_MSB;
      end else if (step_in && (bit_q != `SAPR_RES_ZERO)) begin
         trial_out <= (cmp_hi_in ? trial_out : (trial_out & ~bit_q)) | (bit_q >> 1);
         bit_q     <= bit_q >> 1;
      end
   end
endmodule
`default_nettype wire

/* hdl/sapr_top.v */
// Control and parallel readout of a 16-bit successive approximation converter
//
// Contract
// - Start falling edge moves sample into hold
// - Busy high from start until conversion done
// - Conversion timed by own clock only
// - Conversion lasts 610 ns; here 17 clocks, 1700 ns
// - Sampling starts at later of busy/select fall
// - Bus driven only when select and read low
// - Result is unsigned straight binary
// - Byte select low gives full word
// - Byte select high: low byte up, ones below
// - Reset asynchronous active low, held 20 ns
// - Reset abandons conversion at once
// - Reset clears output latches to zero
// - Sampling resumes promptly after reset
`timescale 1ns/1ps
`default_nettype none
`include "sapr_consts.vh"
module sapr_top (
   input  wire        CLK_IN,
   input  wire        RST_IN,
   input  wire        RESET_N_IN,
   input  wire        CONVERSION_START_N_IN,
   input  wire        CS_N_IN,
   input  wire        RD_N_IN,
   input  wire        BYTE_SEL_IN,
   input  wire        CMP_HI_IN,
   output wire        BUSY_OUT,
   output wire        SAMPLING_OUT,
   output wire [15:0] DATA_BUS_PINS_OUT,
   output wire        DATA_BUS_PINS_OE_OUT,
   output wire [15:0] TRIAL_CODE_OUT
);
   // -----------------------------
   // Constants and states
   // -----------------------------
   localparam [`SAPR_CNT_W-1:0] CONV_CYC = `SAPR_CONV_CYCLES;
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_CONV = 3'h2;
   localparam [2:0] ST_WAIT = 3'h4;

   // -----------------------------
   // Reset combine and input sync
   // -----------------------------
   localparam [`SAPR_PIN_N-1:0] PIN_IDLE = `SAPR_PIN_IDLE;
   wire                         arst = RST_IN | ~RESET_N_IN;
   wire [`SAPR_PIN_N-1:0]       pin_raw;
   wire [`SAPR_PIN_N-1:0]       pin_sync;
   assign pin_raw[`SAPR_PIN_CS] = CS_N_IN;
   assign pin_raw[`SAPR_PIN_CV] = CONVERSION_START_N_IN;
   assign pin_raw[`SAPR_PIN_RD] = RD_N_IN;
   assign pin_raw[`SAPR_PIN_BY] = BYTE_SEL_IN;
   // Two flops on the select, start, read and byte select pins before any logic reads them
   genvar si;
   generate
      for (si = 0; si < `SAPR_PIN_N; si = si + 1) begin : g_sync
         reg [1:0] sync_q;
         always @(posedge CLK_IN or posedge arst) begin
            if (arst) begin
               sync_q <= {2{PIN_IDLE[si]}};
            end else begin
               sync_q <= {sync_q[0], pin_raw[si]};
            end
         end
         assign pin_sync[si] = sync_q[1];
      end
   endgenerate

   // -----------------------------
   // Start edge detect
   // -----------------------------
   wire cs_n    = pin_sync[`SAPR_PIN_CS];
   wire cv_n    = pin_sync[`SAPR_PIN_CV];
   wire rd_n    = pin_sync[`SAPR_PIN_RD];
   wire byte_hi = pin_sync[`SAPR_PIN_BY];
   reg  cv_prev_q;
   always @(posedge CLK_IN or posedge arst) begin
      if (arst) begin
         cv_prev_q <= 1'b1;
      end else begin
         cv_prev_q <= cv_n;
      end
   end
   // Falling edge of the start pin, honoured only with select low
   wire start = cv_prev_q & ~cv_n & ~cs_n;

   // -----------------------------
   // Conversion sequencer
   // -----------------------------
   // Busy spans one clock per result bit plus the latch clock
   localparam [`SAPR_CNT_W-1:0] CNT_ONE = {{(`SAPR_CNT_W-1){1'b0}}, 1'b1};
   reg  [2:0]             st_q;
   reg  [2:0]             st_d;
   reg  [`SAPR_CNT_W-1:0] cnt_q;
   reg  [`SAPR_CNT_W-1:0] cnt_d;
   reg                    samp_q;
   reg                    samp_d;
   wire [15:0]            trial;
   wire                   in_conv  = (st_q == ST_CONV);
   wire                   start_ok = start & (st_q == ST_IDLE);
   wire                   done     = in_conv && (cnt_q == CONV_CYC - CNT_ONE);
   always @* begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      samp_d = samp_q;
      case (st_q)
         ST_IDLE: begin
            if (start_ok) begin
               st_d   = ST_CONV;
               cnt_d  = {`SAPR_CNT_W{1'b0}};
               samp_d = 1'b0;
            end
         end
         ST_CONV: begin
            cnt_d = cnt_q + CNT_ONE;
            if (done) begin
               st_d   = cs_n ? ST_WAIT : ST_IDLE;
               samp_d = ~cs_n;
            end
         end
         ST_WAIT: begin
            if (!cs_n) begin
               st_d   = ST_IDLE;
               samp_d = 1'b1;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end
   always @(posedge CLK_IN or posedge arst) begin
      if (arst) begin
         st_q   <= ST_IDLE;
         cnt_q  <= {`SAPR_CNT_W{1'b0}};
         samp_q <= 1'b1;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         samp_q <= samp_d;
      end
   end

   // -----------------------------
   // Successive approximation
   // -----------------------------
   // The latched comparator answers the trial code within the same clock
   sapr_sar u_sar (
      .clk_in    (CLK_IN),
      .rst_in    (arst),
      .start_in  (start_ok),
      .step_in   (in_conv),
      .cmp_hi_in (CMP_HI_IN),
      .trial_out (trial)
   );

   // -----------------------------
   // Result latch
   // -----------------------------
   // Held until the next conversion ends
   reg [15:0] res_q;
   always @(posedge CLK_IN or posedge arst) begin
      if (arst) begin
         res_q <= `SAPR_RES_ZERO;
      end else if (done) begin
         res_q <= trial;
      end
   end

   // -----------------------------
   // Output enable
   // -----------------------------
   // Bus drive follows the synchronised select and read strobe
   reg oe_q;
   always @(posedge CLK_IN or posedge arst) begin
      if (arst) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= ~cs_n & ~rd_n;
      end
   end

   // -----------------------------
   // Byte lane steering
   // -----------------------------
   wire [`SAPR_BYTE_W-1:0] ones_byte = `SAPR_ONES_BYTE;
   wire [15:0]             bus_d;
   reg  [15:0]             bus_q;
   genvar bi;
   generate
      for (bi = 0; bi < `SAPR_BYTE_W; bi = bi + 1) begin : g_lane
         assign bus_d[bi + `SAPR_BYTE_W] = byte_hi ? res_q[bi] : res_q[bi + `SAPR_BYTE_W];
         assign bus_d[bi]                = byte_hi ? ones_byte[bi] : res_q[bi];
      end
   endgenerate
   always @(posedge CLK_IN or posedge arst) begin
      if (arst) begin
         bus_q <= `SAPR_RES_ZERO;
      end else begin
         bus_q <= bus_d;
      end
   end

   // -----------------------------
   // Status outputs
   // -----------------------------
   assign BUSY_OUT             = in_conv;
   assign SAMPLING_OUT         = samp_q;

   // -----------------------------
   // Data outputs
   // -----------------------------
   assign DATA_BUS_PINS_OUT    = bus_q;
   assign DATA_BUS_PINS_OE_OUT = oe_q;
   assign TRIAL_CODE_OUT       = trial;
endmodule
`default_nettype wire

/* verification/sapr_ana_model.sv */
// Comparator model facing the trial code
`timescale 1ns/1ps
`default_nettype none
module sapr_ana_model (
   input  wire logic [15:0] level_in,
   input  wire logic [15:0] trial_in,
   output logic             cmp_hi_out
);
   assign cmp_hi_out = (level_in >= trial_in);
endmodule
`default_nettype wire

/* verification/sapr_monitor.sv */
// Port assertions for the converter readout
`timescale 1ns/1ps
`default_nettype none
module sapr_monitor (
   input wire logic        CLK_IN,
   input wire logic        RST_IN,
   input wire logic        RESET_N_IN,
   input wire logic        CS_N_IN,
   input wire logic        RD_N_IN,
   input wire logic        BYTE_SEL_IN,
   input wire logic        BUSY_OUT,
   input wire logic        SAMPLING_OUT,
   input wire logic [15:0] DATA_BUS_PINS_OUT,
   input wire logic        DATA_BUS_PINS_OE_OUT,
   input wire logic [15:0] TRIAL_CODE_OUT
);
   wire logic rst = RST_IN || !RESET_N_IN;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (rst);
   localparam int CONV_CYC = 17;
   logic [5:0] busy_run_q;
   always @(posedge CLK_IN or posedge rst) begin
      if (rst) begin
         busy_run_q <= 6'h00;
      end else if (BUSY_OUT) begin
         busy_run_q <= busy_run_q + 6'h01;
      end else begin
         busy_run_q <= 6'h00;
      end
   end
   a_busy_len: assert property ($fell(BUSY_OUT) |-> busy_run_q == CONV_CYC) else $error("busy len");
   a_busy_cap: assert property (busy_run_q <= CONV_CYC) else $error("busy long");
   a_trial_mid: assert property ($rose(BUSY_OUT) |-> TRIAL_CODE_OUT == 16'h8000) else $error("trial");
   a_hold_mode: assert property (BUSY_OUT |-> !SAMPLING_OUT) else $error("hold");
   a_oe_need: assert property (DATA_BUS_PINS_OE_OUT |-> $past(!CS_N_IN && !RD_N_IN, 3)) else $error("oe");
   a_oe_off: assert property ((CS_N_IN || RD_N_IN)[*4] |-> !DATA_BUS_PINS_OE_OUT) else $error("oe off");
   a_low_ones: assert property (DATA_BUS_PINS_OE_OUT && $past(BYTE_SEL_IN, 3) && $past(BYTE_SEL_IN, 4)
      |-> DATA_BUS_PINS_OUT[7:0] == 8'hFF) else $error("low byte");
   a_samp_start: assert property ($fell(BUSY_OUT) && !CS_N_IN |-> ##[0:2] SAMPLING_OUT) else $error("samp");
   a_rst_clear: assert property (disable iff (1'b0) rst |-> !BUSY_OUT && SAMPLING_OUT
      && !DATA_BUS_PINS_OE_OUT && DATA_BUS_PINS_OUT == 16'h0000) else $error("reset");
   c_done: cover property ($fell(BUSY_OUT));
   c_byte: cover property (DATA_BUS_PINS_OE_OUT && BYTE_SEL_IN);
   c_samp: cover property ($rose(SAMPLING_OUT));
endmodule
bind sapr_top sapr_monitor u_mon (.*);
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the converter readout
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk = 0, rst = 1, rst_n = 1, cst_n = 1, cs_n = 1, rd_n = 1, bsel = 0;
   logic        busy, samp, oe, cmp;
   logic [15:0] bus, trial, lvl = 16'h0000;
   int          n_mismatch = 0, total_checks = 0;
   sapr_top uut (.CLK_IN(clk), .RST_IN(rst), .RESET_N_IN(rst_n), .CONVERSION_START_N_IN(cst_n),
      .CS_N_IN(cs_n), .RD_N_IN(rd_n), .BYTE_SEL_IN(bsel), .CMP_HI_IN(cmp), .BUSY_OUT(busy),
      .SAMPLING_OUT(samp), .DATA_BUS_PINS_OUT(bus), .DATA_BUS_PINS_OE_OUT(oe), .TRIAL_CODE_OUT(trial));
   sapr_ana_model u_ana (.level_in(lvl), .trial_in(trial), .cmp_hi_out(cmp));
   initial forever #50 clk = ~clk;
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task wait_busy(input logic v);
      for (int i = 0; i < 40 && busy !== v; i++) tick(1);
      if (busy !== v) begin
         chk(busy, v);
         tally_and_finish;
      end
   endtask
   task start;
      cs_n = 0;
      rd_n = 1;
      cst_n = 0;
      tick(4);
      cst_n = 1;
      wait_busy(1);
   endtask
   task conv(input logic [15:0] v);
      lvl = v;
      bsel = 0;
      start;
      chk(samp, 0);
      wait_busy(0);
      tick(3);
      chk(samp, 1);
      rd_n = 0;
      tick(4);
      chk(oe, 1);
      chk(bus, v);
      bsel = 1;
      tick(4);
      chk(bus, {v[7:0], 8'hFF});
      cs_n = 1;
      tick(4);
      chk(oe, 0);
      rd_n = 1;
      $display("conv %h done", v);
   endtask
   task rst_mid;
      start;
      rst_n = 0;
      #30;
      chk(busy, 0);
      tick(1);
      rst_n = 1;
      tick(1);
      chk(samp, 1);
      rd_n = 0;
      bsel = 0;
      tick(4);
      chk(bus, 16'h0000);
      $display("reset test done");
   endtask
   initial begin
      tick(6);
      rst = 0;
      tick(2);
      conv(16'h0000);
      conv(16'h8000);
      conv(16'h7FFF);
      conv(16'hFFFF);
      rst_mid;
      tally_and_finish;
   end
endmodule
`default_nettype wire
